// ---- hw/sst_pkg.sv ----
package sst_pkg;

  // Serial clock select codes and the transmit-only transfer mode.
  localparam logic [2:0] SCK_EXT = 3'h7;
  localparam logic [2:0] SCK_LOWCODE = 3'h0;
  localparam logic [2:0] SCK_FASTEST = 3'h6;
  localparam logic [1:0] MODE_TX = 2'h0;

  // Half-period lengths in core clocks for codes 000 to 110 (fc/2^12 .. fc/2^3).
  localparam logic [11:0] HALF_000 = 12'h800;
  localparam logic [11:0] HALF_001 = 12'h080;
  localparam logic [11:0] HALF_010 = 12'h040;
  localparam logic [11:0] HALF_011 = 12'h020;
  localparam logic [11:0] HALF_100 = 12'h010;
  localparam logic [11:0] HALF_101 = 12'h008;
  localparam logic [11:0] HALF_110 = 12'h004;
  // Half-period of fs/2^4 in low-frequency clock rising edges.
  localparam logic [11:0] HALF_FS = 12'h008;

  // Falls per byte, bit counter field and reset values.
  localparam logic [3:0] BYTE_FALLS = 4'h8;
  localparam logic [3:0] LAST_SHIFT = 4'h7;
  localparam logic [3:0] FIRST_FALL = 4'h1;
  localparam logic [7:0] TXBUF_RST = 8'h00;
  localparam logic DOUT_IDLE = 1'b1;
  localparam logic SCK_IDLE = 1'b1;
  localparam int SYNC_STAGES = 3;

  typedef enum logic [2:0] {ST_IDLE, ST_LEAD, ST_LOW, ST_HIGH, ST_WAIT} sst_state_t;

endpackage : sst_pkg

// ---- hw/sst_clk_if.sv ----
`timescale 1ns/1ps
interface sst_clk_if;
  logic run;
  logic [2:0] clkSel;
  logic prescSel;
  logic slowMode;
  logic halfTick;
  logic extRise;
  logic extFall;
  logic clkValid;
  modport gen (input run, clkSel, prescSel, slowMode,
               output halfTick, extRise, extFall, clkValid);
  modport core (output run, clkSel, prescSel, slowMode,
                input halfTick, extRise, extFall, clkValid);
endinterface : sst_clk_if

// ---- hw/sst_clk_gen.sv ----
`timescale 1ns/1ps
module sst_clk_gen #(
  parameter int DIV_W = 12
) (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic serialClockPinIn,
  input wire logic lowFreqClkIn,
  sst_clk_if.gen clkBus
);

  if (DIV_W < 12) begin : g_chk
    $error("sst_clk_gen: DIV_W must be at least 12");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers: index 0 is the external serial clock, 1 the fs clock.
  logic [1:0] pinIn;
  logic [1:0] lvl_r;
  logic [1:0] lvl_nxt;
  logic [1:0] rise_r;
  logic [1:0] fall_r;
  assign pinIn = {lowFreqClkIn, serialClockPinIn};

  for (genvar i = 0; i < 2; i++) begin : g_sync
    logic [sst_pkg::SYNC_STAGES-1:0] stg_r;
    always_ff @(posedge core_clk) begin
      if (srst) begin
        stg_r <= '1;
      end else begin
        stg_r <= {stg_r[sst_pkg::SYNC_STAGES-2:0], pinIn[i]};
      end
    end
    // A change counts once the second and third stages agree.
    assign lvl_nxt[i] = (stg_r[1] == stg_r[2]) ? stg_r[1] : lvl_r[i];
    always_ff @(posedge core_clk) begin
      if (srst) begin
        lvl_r[i] <= 1'b1;
        rise_r[i] <= 1'b0;
        fall_r[i] <= 1'b0;
      end else begin
        lvl_r[i] <= lvl_nxt[i];
        rise_r[i] <= lvl_nxt[i] & ~lvl_r[i];
        fall_r[i] <= ~lvl_nxt[i] & lvl_r[i];
      end
    end
  end

  assign clkBus.extRise = rise_r[0];
  assign clkBus.extFall = fall_r[0];

  ////////////////////////////////////////////////////////////////////////////
  // Internal rate selection and half-period divider.
  logic useFs;
  logic [DIV_W-1:0] halfLim;
  logic [DIV_W-1:0] cnt_r;
  logic step;
  logic tick_r;

  assign useFs = (clkBus.clkSel == sst_pkg::SCK_LOWCODE) &&
                 (clkBus.prescSel || clkBus.slowMode);
  // In slow modes only the fs code is a valid internal rate; codes 001 to 110 are reserved.
  assign clkBus.clkValid = !clkBus.slowMode || (clkBus.clkSel == sst_pkg::SCK_LOWCODE);

  always_comb begin
    case (clkBus.clkSel)
      3'h0: halfLim = DIV_W'(useFs ? sst_pkg::HALF_FS : sst_pkg::HALF_000);
      3'h1: halfLim = DIV_W'(sst_pkg::HALF_001);
      3'h2: halfLim = DIV_W'(sst_pkg::HALF_010);
      3'h3: halfLim = DIV_W'(sst_pkg::HALF_011);
      3'h4: halfLim = DIV_W'(sst_pkg::HALF_100);
      3'h5: halfLim = DIV_W'(sst_pkg::HALF_101);
      3'h6: halfLim = DIV_W'(sst_pkg::HALF_110);
      default: halfLim = DIV_W'(sst_pkg::HALF_110);
    endcase
  end

  assign step = useFs ? rise_r[1] : 1'b1;

  always_ff @(posedge core_clk) begin
    if (srst || !clkBus.run) begin
      cnt_r <= '0;
      tick_r <= 1'b0;
    end else begin
      tick_r <= step && (cnt_r == halfLim - DIV_W'(1));
      if (step) begin
        cnt_r <= (cnt_r == halfLim - DIV_W'(1)) ? '0 : cnt_r + DIV_W'(1);
      end
    end
  end

  assign clkBus.halfTick = tick_r;

endmodule : sst_clk_gen

// ---- hw/sst_top.sv ----
`timescale 1ns/1ps
// How it works
// - Non-external codes drive serial clock out.
// - Internal clock idles high outside transfers.
// - Missing next byte stops internal clock, waits.
// - Clock resumes within one period after write.
// - Codes divide fc or fs as tabled.
// - External code shifts on pin-supplied clock.
// - Shift out on fall, sample on rise.
// - Direction bit picks MSB or LSB first.
// - Mode code 00 selects transmit only.
// - Busy flag sets at serial clock fall.
// - Monitor flag high first to eighth fall.
// - Write clears empty; rise sets; fall interrupts.
// - Internal start waits for buffered byte.
// - Internal start loads within one period.
// - External start loads on first fall.
// - Byte written in time follows seamlessly.
// - External clock: empty buffer at shift flags underrun, interrupt.
// - Start cleared: finish byte, idle, data high.
// - Inhibit stops at once, resets everything.
module sst_top (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic [2:0] clockSelect,
  input wire logic prescalerSourceSelect,
  input wire logic slowMode,
  input wire logic bitOrderSelect,
  input wire logic [1:0] transferModeField,
  input wire logic startWrite,
  input wire logic startWriteValue,
  input wire logic inhibitWrite,
  input wire logic txWrite,
  input wire logic [7:0] txWriteData,
  input wire logic txErrClear,
  input wire logic serialClockPinIn,
  input wire logic lowFreqClkIn,
  output logic serialClockPinOut,
  output logic serialClockPinOe,
  output logic serialDataOutPin,
  output logic transferStartBit,
  output logic operationStatusFlag,
  output logic clockCountMonitorFlag,
  output logic txBufferEmpty,
  output logic txUnderrunErrorFlag,
  output logic serialInterruptRequest
);

  ////////////////////////////////////////////////////////////////////////////
  // Clock generator.
  sst_clk_if clkBus ();

  sst_pkg::sst_state_t st_r;
  logic internal;
  logic riseEv;
  logic fallEv;

  assign internal = (clockSelect != sst_pkg::SCK_EXT);
  assign clkBus.run = (st_r != sst_pkg::ST_IDLE);
  assign clkBus.clkSel = clockSelect;
  assign clkBus.prescSel = prescalerSourceSelect;
  assign clkBus.slowMode = slowMode;

  sst_clk_gen #(.DIV_W(12)) sst_clk_gen_i (
    .core_clk(core_clk),
    .srst(srst),
    .serialClockPinIn(serialClockPinIn),
    .lowFreqClkIn(lowFreqClkIn),
    .clkBus(clkBus)
  );

  // Rising and falling edges come from the divider or from the pin.
  assign riseEv = internal ? clkBus.halfTick : clkBus.extRise;
  assign fallEv = internal ? clkBus.halfTick : clkBus.extFall;

  ////////////////////////////////////////////////////////////////////////////
  // Transfer events.
  logic [7:0] txBuf_r;
  logic [7:0] sh_r;
  logic [3:0] bitCnt_r;
  logic bufValid_r;
  logic loadPend_r;
  logic irqPend_r;
  logic modeTx;
  logic startInt;
  logic loadEv;
  logic shiftEv;
  logic stopEv;
  logic goWait;
  logic acceptWr;
  logic underrunEv;
  logic byteDone;

  assign modeTx = (transferModeField == sst_pkg::MODE_TX);
  assign byteDone = (bitCnt_r == sst_pkg::BYTE_FALLS);
  assign acceptWr = txWrite && txBufferEmpty && !inhibitWrite;
  assign startInt = (st_r == sst_pkg::ST_IDLE) && internal && clkBus.clkValid &&
                    transferStartBit && bufValid_r && modeTx;
  assign loadEv = ((st_r == sst_pkg::ST_LEAD) && clkBus.halfTick) ||
                  ((st_r == sst_pkg::ST_IDLE) && !internal && transferStartBit &&
                   modeTx && clkBus.extFall) ||
                  ((st_r == sst_pkg::ST_HIGH) && byteDone && transferStartBit && fallEv &&
                   (bufValid_r || !internal));
  assign goWait = (st_r == sst_pkg::ST_HIGH) && byteDone && transferStartBit &&
                  internal && !bufValid_r;
  assign shiftEv = (st_r == sst_pkg::ST_HIGH) && !byteDone && fallEv;
  // Stopping one cycle after the eighth rise keeps the last bit stable at that rise.
  assign stopEv = ((st_r == sst_pkg::ST_HIGH) && byteDone && !transferStartBit) ||
                  ((st_r == sst_pkg::ST_WAIT) && !transferStartBit);
  assign underrunEv = loadEv && !bufValid_r;

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer, serial clock and shift register.
  always_ff @(posedge core_clk) begin
    if (srst || inhibitWrite) begin
      st_r <= sst_pkg::ST_IDLE;
      serialClockPinOut <= sst_pkg::SCK_IDLE;
      serialDataOutPin <= sst_pkg::DOUT_IDLE;
      sh_r <= sst_pkg::TXBUF_RST;
      bitCnt_r <= '0;
    end else begin
      if (loadEv) begin
        st_r <= sst_pkg::ST_LOW;
        serialClockPinOut <= !internal ? sst_pkg::SCK_IDLE : 1'b0;
        sh_r <= txBuf_r;
        serialDataOutPin <= bitOrderSelect ? txBuf_r[0] : txBuf_r[7];
        bitCnt_r <= sst_pkg::FIRST_FALL;
      end else if (shiftEv) begin
        st_r <= sst_pkg::ST_LOW;
        serialClockPinOut <= !internal;
        sh_r <= bitOrderSelect ? (sh_r >> 1) : (sh_r << 1);
        serialDataOutPin <= bitOrderSelect ? sh_r[1] : sh_r[6];
        bitCnt_r <= bitCnt_r + 4'h1;
      end else if (stopEv) begin
        st_r <= sst_pkg::ST_IDLE;
        serialClockPinOut <= sst_pkg::SCK_IDLE;
        serialDataOutPin <= sst_pkg::DOUT_IDLE;
      end else if (goWait) begin
        st_r <= sst_pkg::ST_WAIT;
      end else if (startInt) begin
        st_r <= sst_pkg::ST_LEAD;
      end else if ((st_r == sst_pkg::ST_WAIT) && bufValid_r) begin
        st_r <= sst_pkg::ST_LEAD;
      end else if ((st_r == sst_pkg::ST_LOW) && riseEv) begin
        st_r <= sst_pkg::ST_HIGH;
        serialClockPinOut <= sst_pkg::SCK_IDLE;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      serialClockPinOe <= 1'b0;
    end else begin
      serialClockPinOe <= internal;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Transmit buffer and empty flag.
  always_ff @(posedge core_clk) begin
    if (srst || inhibitWrite) begin
      txBuf_r <= sst_pkg::TXBUF_RST;
      bufValid_r <= 1'b0;
      txBufferEmpty <= 1'b1;
      loadPend_r <= 1'b0;
    end else begin
      if (acceptWr) begin
        txBuf_r <= txWriteData;
      end
      bufValid_r <= acceptWr || (bufValid_r && !loadEv);
      if (loadEv) begin
        loadPend_r <= 1'b1;
      end else if ((st_r == sst_pkg::ST_LOW) && riseEv) begin
        loadPend_r <= 1'b0;
      end
      // The set at the rising edge wins over a write in the same cycle.
      if (loadPend_r && (st_r == sst_pkg::ST_LOW) && riseEv) begin
        txBufferEmpty <= 1'b1;
      end else if (acceptWr) begin
        txBufferEmpty <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Start bit, status flags, underrun and interrupt request.
  always_ff @(posedge core_clk) begin
    if (srst || inhibitWrite) begin
      transferStartBit <= 1'b0;
      operationStatusFlag <= 1'b0;
      clockCountMonitorFlag <= 1'b0;
      txUnderrunErrorFlag <= 1'b0;
      irqPend_r <= 1'b0;
      serialInterruptRequest <= 1'b0;
    end else begin
      if (startWrite) begin
        transferStartBit <= startWriteValue;
      end
      if (loadEv) begin
        operationStatusFlag <= 1'b1;
      end else if (stopEv) begin
        operationStatusFlag <= 1'b0;
      end
      if (loadEv) begin
        clockCountMonitorFlag <= 1'b1;
      end else if (shiftEv && (bitCnt_r == sst_pkg::LAST_SHIFT)) begin
        clockCountMonitorFlag <= 1'b0;
      end
      // Hardware setting the error wins over a software clear.
      if (underrunEv) begin
        txUnderrunErrorFlag <= 1'b1;
      end else if (txErrClear) begin
        txUnderrunErrorFlag <= 1'b0;
      end
      if (loadPend_r && (st_r == sst_pkg::ST_LOW) && riseEv) begin
        irqPend_r <= 1'b1;
      end else if (loadEv || shiftEv) begin
        irqPend_r <= 1'b0;
      end
      serialInterruptRequest <= underrunEv || (irqPend_r && (loadEv || shiftEv));
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks.
  property p_int_drive;
    @(posedge core_clk) disable iff (srst)
    (clockSelect != sst_pkg::SCK_EXT) |=> serialClockPinOe;
  endproperty
  a_int_drive: assert property (p_int_drive) else $error("serial clock not driven");

  property p_idle_high;
    @(posedge core_clk) disable iff (srst)
    (st_r == sst_pkg::ST_IDLE) |-> serialClockPinOut && serialDataOutPin;
  endproperty
  a_idle_high: assert property (p_idle_high) else $error("idle pins not high");

  property p_wait_high;
    @(posedge core_clk) disable iff (srst)
    (st_r == sst_pkg::ST_WAIT) |-> serialClockPinOut && !loadEv;
  endproperty
  a_wait_high: assert property (p_wait_high) else $error("clock moved during wait");

  property p_wait_release;
    @(posedge core_clk) disable iff (srst || inhibitWrite)
    ((st_r == sst_pkg::ST_WAIT) && bufValid_r && transferStartBit &&
     (clockSelect == sst_pkg::SCK_FASTEST)) |-> ##[1:8] !serialClockPinOut;
  endproperty
  a_wait_release: assert property (p_wait_release) else $error("wait not released in time");

  property p_mode_gate;
    @(posedge core_clk) disable iff (srst)
    ((st_r == sst_pkg::ST_IDLE) && !modeTx) |=> (st_r == sst_pkg::ST_IDLE);
  endproperty
  a_mode_gate: assert property (p_mode_gate) else $error("started outside transmit mode");

  property p_busy_at_fall;
    @(posedge core_clk) disable iff (srst)
    ($rose(operationStatusFlag) && internal) |-> $fell(serialClockPinOut);
  endproperty
  a_busy_at_fall: assert property (p_busy_at_fall) else $error("busy flag off the fall");

  property p_monitor_span;
    @(posedge core_clk) disable iff (srst)
    $fell(clockCountMonitorFlag) && !$past(inhibitWrite) && !$past(srst) |->
      (bitCnt_r == sst_pkg::BYTE_FALLS);
  endproperty
  a_monitor_span: assert property (p_monitor_span) else $error("monitor fell early");

  property p_write_clears;
    @(posedge core_clk) disable iff (srst)
    (acceptWr && !(loadPend_r && (st_r == sst_pkg::ST_LOW) && riseEv)) |=> !txBufferEmpty;
  endproperty
  a_write_clears: assert property (p_write_clears) else $error("write left empty set");

  property p_no_byte_no_start;
    @(posedge core_clk) disable iff (srst)
    ((st_r == sst_pkg::ST_IDLE) && internal && !bufValid_r) |=> (st_r == sst_pkg::ST_IDLE);
  endproperty
  a_no_byte_no_start: assert property (p_no_byte_no_start) else $error("started empty");

  property p_underrun_irq;
    @(posedge core_clk) disable iff (srst)
    $rose(txUnderrunErrorFlag) |-> serialInterruptRequest;
  endproperty
  a_underrun_irq: assert property (p_underrun_irq) else $error("underrun without request");

  property p_stop_state;
    @(posedge core_clk) disable iff (srst)
    (st_r != sst_pkg::ST_IDLE) ##1 (st_r == sst_pkg::ST_IDLE) |->
      !operationStatusFlag && serialDataOutPin;
  endproperty
  a_stop_state: assert property (p_stop_state) else $error("stop left flags set");

  property p_inhibit;
    @(posedge core_clk) disable iff (srst)
    inhibitWrite |=> (st_r == sst_pkg::ST_IDLE) && !transferStartBit && txBufferEmpty &&
                     !txUnderrunErrorFlag;
  endproperty
  a_inhibit: assert property (p_inhibit) else $error("inhibit did not reset");

  c_back_to_back: cover property (@(posedge core_clk) disable iff (srst)
    (st_r == sst_pkg::ST_HIGH) && byteDone && loadEv && bufValid_r);
  c_underrun: cover property (@(posedge core_clk) disable iff (srst) underrunEv);
  c_auto_wait: cover property (@(posedge core_clk) disable iff (srst)
    (st_r == sst_pkg::ST_WAIT) ##1 (st_r == sst_pkg::ST_LEAD));

endmodule : sst_top

// ---- dv/sst_ext_dev.sv ----
`timescale 1ns/1ps
module sst_ext_dev (
  input wire logic sckWire,
  input wire logic dataIn,
  output logic sckLevel,
  output logic [7:0] rxByte,
  output logic [3:0] rxCount
);
  initial begin
    sckLevel = 1'b1;
    rxByte = 8'h00;
    rxCount = 4'h0;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Data is taken on the rising pin edge, while the sender holds it still.
  always @(posedge sckWire) begin
    rxByte <= {rxByte[6:0], dataIn};
    rxCount <= rxCount + 4'h1;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Eight pulses per frame; the clock rests high between frames.
  task automatic frame(input int halfNs);
    repeat (8) begin
      #(halfNs) sckLevel = 1'b0;
      #(halfNs) sckLevel = 1'b1;
    end
    #(halfNs);
  endtask : frame
endmodule : sst_ext_dev

// ---- dv/sst_top_bench.sv ----
`timescale 1ns/1ps
module sst_top_bench;
  logic core_clk, srst, prescSel, slow, dir, stW, stV, inh, txW, errClr, fs, extEn;
  logic [2:0] sel;
  logic [1:0] mode;
  logic [7:0] txD, pByte;
  logic [3:0] pCnt;
  logic sckOut, sckOe, dout, startBit, busy, mon, empty, err, irq, sckWire, pLvl;
  int error_cnt = 0;
  int num_checks = 0;
  int irqCnt = 0;
  int waited;

  // The clock pin has a pull-up; whoever enables a driver sets its level.
  assign sckWire = sckOe ? sckOut : (extEn ? pLvl : 1'b1);

  sst_top sst_top_i (
    .core_clk(core_clk), .srst(srst), .clockSelect(sel), .prescalerSourceSelect(prescSel),
    .slowMode(slow), .bitOrderSelect(dir), .transferModeField(mode), .startWrite(stW),
    .startWriteValue(stV), .inhibitWrite(inh), .txWrite(txW), .txWriteData(txD),
    .txErrClear(errClr), .serialClockPinIn(sckWire), .lowFreqClkIn(fs),
    .serialClockPinOut(sckOut), .serialClockPinOe(sckOe), .serialDataOutPin(dout),
    .transferStartBit(startBit), .operationStatusFlag(busy), .clockCountMonitorFlag(mon),
    .txBufferEmpty(empty), .txUnderrunErrorFlag(err), .serialInterruptRequest(irq)
  );

  sst_ext_dev ext_i (
    .sckWire(sckWire), .dataIn(dout), .sckLevel(pLvl), .rxByte(pByte), .rxCount(pCnt)
  );

  always @(posedge core_clk) begin
    if (irq === 1'b1) begin
      irqCnt <= irqCnt + 1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic conclude();
    if (error_cnt == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : conclude

  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask : cyc

  task automatic set_start(input logic v);
    stV <= v;
    stW <= 1'b1;
    cyc(1);
    stW <= 1'b0;
    cyc(1);
  endtask : set_start

  task automatic put(input logic [7:0] d);
    txD <= d;
    txW <= 1'b1;
    cyc(1);
    txW <= 1'b0;
    cyc(1);
  endtask : put

  task automatic inhibit();
    inh <= 1'b1;
    cyc(1);
    inh <= 1'b0;
    cyc(1);
  endtask : inhibit

  function automatic logic [15:0] stat();
    return {8'h00, sckWire, sckOe, dout, empty, busy, mon, err, startBit};
  endfunction : stat

  function automatic logic pick(input int k);
    case (k)
      0: return sckWire;
      1: return busy;
      default: return empty;
    endcase
  endfunction : pick

  // Counts whole cycles until the chosen output reads the wanted level.
  task automatic wait_for(input int k, input logic v, input int lim);
    waited = 0;
    cyc(1);
    while (pick(k) !== v && waited < lim) begin
      cyc(1);
      waited++;
    end
    if (pick(k) !== v) check(16'(pick(k)), 16'(v));
  endtask : wait_for

  task automatic wait_rx(input logic [3:0] n);
    waited = 0;
    while (pCnt !== n && waited < 2000) begin
      cyc(1);
      waited++;
    end
    if (pCnt !== n) check(16'(pCnt), 16'(n));
  endtask : wait_rx

  ////////////////////////////////////////////////////////////////////////////////
  // Half periods of every internal rate, then fs/16 through slow mode and prescaler.
  task automatic t_rate();
    int half [9] = '{2048, 128, 64, 32, 16, 8, 4, 128, 128};
    for (int k = 0; k < 9; k++) begin
      sel <= (k > 6) ? 3'h0 : 3'(k);
      slow <= (k == 7);
      prescSel <= (k == 8);
      cyc(2);
      put(8'h55);
      set_start(1'b1);
      wait_for(0, 1'b0, 3 * half[k] + 8);
      check(16'(sckOe), 16'h0001);
      wait_for(0, 1'b1, half[k] + 4);
      wait_for(0, 1'b0, half[k] + 4);
      if (k > 6) check(16'(waited >= 126 && waited <= 128), 16'h0001);
      else check(16'(waited), 16'(half[k] - 1));
      inhibit();
      check(stat(), 16'h00f0);
    end
    slow <= 1'b0;
    prescSel <= 1'b0;
  endtask : t_rate

  task automatic t_refuse();
    mode <= 2'h1;
    put(8'h0f);
    set_start(1'b1);
    cyc(40);
    check(stat(), 16'h00e1);
    sel <= 3'h1;
    slow <= 1'b1;
    mode <= 2'h0;
    cyc(40);
    check(stat(), 16'h00e1);
    inhibit();
    slow <= 1'b0;
  endtask : t_refuse

  task automatic t_int();
    int base;
    logic [3:0] r0;
    sel <= 3'h6;
    dir <= 1'b0;
    set_start(1'b1);
    cyc(30);
    check(stat(), 16'h00f1);
    base = irqCnt;
    r0 = pCnt;
    put(8'ha5);
    check(16'(empty), 16'h0000);
    wait_for(0, 1'b0, 20);
    cyc(2);
    check(16'({busy, mon}), 16'h0003);
    wait_for(2, 1'b1, 16);
    put(8'h3c);
    wait_rx(r0 + 4'h8);
    check(16'(pByte), 16'h00a5);
    wait_rx(r0);
    check(16'(pByte), 16'h003c);
    cyc(40);
    check(16'({sckWire, busy, pCnt}), 16'({2'b11, r0}));
    put(8'h81);
    wait_for(0, 1'b0, 8);
    set_start(1'b0);
    wait_for(1, 1'b0, 80);
    check(16'(pByte), 16'h0081);
    check(stat(), 16'h00f0);
    check(16'(irqCnt - base), 16'h0003);
  endtask : t_int

  task automatic t_lsb();
    dir <= 1'b1;
    put(8'h1e);
    set_start(1'b1);
    wait_for(0, 1'b0, 20);
    set_start(1'b0);
    wait_for(1, 1'b0, 80);
    check(16'(pByte), 16'h0078);
  endtask : t_lsb

  task automatic t_ext();
    int base;
    sel <= 3'h7;
    dir <= 1'b0;
    extEn <= 1'b1;
    cyc(3);
    check(16'(sckOe), 16'h0000);
    put(8'h96);
    set_start(1'b1);
    base = irqCnt;
    ext_i.frame(67);
    cyc(6);
    check(16'({pByte, busy, empty}), 16'h025b);
    // No refill: the second frame underruns, and start is cleared during it.
    fork
      ext_i.frame(67);
      begin
        cyc(30);
        set_start(1'b0);
      end
    join
    cyc(6);
    check(16'({err, busy, dout}), 16'h0005);
    check(16'(irqCnt - base), 16'h0003);
    errClr <= 1'b1;
    cyc(1);
    errClr <= 1'b0;
    cyc(1);
    check(16'(err), 16'h0000);
    extEn <= 1'b0;
  endtask : t_ext

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  initial begin
    fs = 1'b0;
    #3;
    forever #80 fs = ~fs;
  end

  initial begin
    #300_000;
    error_cnt++;
    conclude();
  end

  initial begin
    srst = 1'b1;
    sel = 3'h6;
    prescSel = 1'b0;
    slow = 1'b0;
    dir = 1'b0;
    mode = 2'h0;
    stW = 1'b0;
    stV = 1'b0;
    inh = 1'b0;
    txW = 1'b0;
    txD = 8'h00;
    errClr = 1'b0;
    extEn = 1'b0;
    cyc(16);
    srst <= 1'b0;
    cyc(3);
    check(stat(), 16'h00f0);
    t_rate();
    t_refuse();
    t_int();
    t_lsb();
    t_ext();
    conclude();
  end
endmodule : sst_top_bench
